// ---- design/scan_debounce_defs.svh ----
`ifndef SCAN_DEBOUNCE_DEFS_SVH
`define SCAN_DEBOUNCE_DEFS_SVH

// Register byte addresses
`define SD_ADDR_CTRL     8'h00
`define SD_ADDR_STAT     8'h04
`define SD_ADDR_FLD      8'h10
`define SD_FLD_STRIDE    8'h04

// Plane control word field positions
`define SD_C_N           0
`define SD_C_PS          5
`define SD_C_NCS         7
`define SD_C_CLREN       12
`define SD_C_CLR         13
`define SD_C_FAST        18
`define SD_C_INTF        19
`define SD_C_RES         21

// Per-field word field positions
`define SD_F_OVR         0
`define SD_F_N           1
`define SD_F_RES         6
`define SD_F_CLR         9

// Status word field positions
`define SD_S_ON          0
`define SD_S_PS          8
`define SD_S_PER         16

// Reset values
`define SD_RST_N         5'h02
`define SD_RST_NCS       5'h01
`define SD_RST_CLR       5'h02
`define SD_RST_RES       3'h1

// Count limits
`define SD_N_MIN         5'h02
`define SD_N_MAX         5'h10
`define SD_NCS_FAST      5'h01
`define SD_CLR_LONG      5'h06
`define SD_CNT_SAT       5'h1F
`define SD_RES_MAX       3'h6

// Scan cycle times in ms: 40/30 short range, 50/40 long range
`define SD_CYC_SHORT_FULL_MS 8'h28
`define SD_CYC_SHORT_FAST_MS 8'h1E
`define SD_CYC_LONG_FULL_MS  8'h32
`define SD_CYC_LONG_FAST_MS  8'h28
`define SD_INTF_STEP_MS      8'h01

// Time base
`define SD_MS_NS         1000000
`define SD_CLK_NS        10
`define SD_CYC_PER_MS    (`SD_MS_NS / `SD_CLK_NS)

`endif

// ---- design/scan_debounce_pkg.sv ----
package scan_debounce_pkg;

   typedef enum logic [1:0] {PS_FAST, PS_ROBUST, PS_USER} ps_mode_e;

   typedef enum logic [2:0] {RES_30, RES_40, RES_50, RES_60, RES_70, RES_150, RES_200} res_e;

   typedef logic [4:0] cnt_t;

   typedef struct packed {
      cnt_t     samples;
      ps_mode_e ps_mode;
      cnt_t     ncs_user;
      logic     clr_en;
      cnt_t     clr_cnt;
      logic     fast_cyc;
      logic [1:0] intf;
      res_e     res;
   } plane_cfg_s;

   typedef struct packed {
      logic     ovr;
      cnt_t     samples;
      res_e     res;
      cnt_t     clr_cnt;
   } field_cfg_s;

endpackage

// ---- design/scan_detection_debounce.sv ----
// Summary of operation
// - An object must be seen on a programmable count of consecutive scans, held between 2 and 16, before a field trips.
// - In fast post-switch mode a single occupied scan right after a case switch trips the field.
// - In robust post-switch mode the first evaluation after a case switch needs the sample count minus one.
// - In user post-switch mode the programmed count is used but never above the sample count minus one.
// - By default a tripped field is restored only after as many consecutive free scans as the detection count.
// - With the clear override on, a separate free-scan count for the plane or the field is used instead.
// - After a long occupancy a free-scan count below 6 is raised to 6.
// - Short-range variants scan every 40 ms, or 30 ms in fast mode.
// - Long-range variants scan every 50 ms, or 40 ms in fast mode.
// - Each field uses the plane sample count and object size unless its own override is set.
// - Object size is one of 30, 40, 50, 60, 70, 150 or 200 mm, with 60 mm only on variants that have it.
// - Each scan period is lengthened by 0, 1, 2 or 3 ms for interference modes one to four.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "scan_debounce_defs.svh"

module scan_detection_debounce #(
   parameter int   NF         = 4,
   parameter int   CYC_PER_MS = `SD_CYC_PER_MS,
   parameter bit   LONG_RANGE = 1'b0,
   parameter bit   HAS_60MM   = 1'b1,
   parameter scan_debounce_pkg::cnt_t LONG_SCANS = 5'h10
) (
   // Clock and reset
   input  wire logic                           sys_clk_i,
   input  wire logic                           rst_i,
   // Register port
   input  wire logic [7:0]                     addr_i,
   input  wire logic [31:0]                    wdata_i,
   input  wire logic                           wr_i,
   input  wire logic                           rd_i,
   output logic      [31:0]                    rdata_o,
   // Scan engine side
   input  wire logic [NF-1:0]                  field_occ_i,
   input  wire logic                           case_switch_i,
   output logic                                scan_tick_o,
   output scan_debounce_pkg::res_e [NF-1:0]    field_res_o,
   // Machine control side
   output logic      [NF-1:0]                  safe_on_o
);
   import scan_debounce_pkg::*;

   localparam int MSW = $clog2(CYC_PER_MS + 1);

   plane_cfg_s        pcfg_ff,    nxt_pcfg;
   field_cfg_s        fcfg_ff     [NF];
   field_cfg_s        nxt_fcfg    [NF];
   logic [31:0]       rdata_ff,   nxt_rdata;
   logic [MSW-1:0]    ms_cnt_ff,  nxt_ms_cnt;
   logic [7:0]        per_cnt_ff, nxt_per_cnt;
   logic              tick_ff,    nxt_tick;
   logic [7:0]        period_w;
   cnt_t              occ_ff      [NF];
   cnt_t              nxt_occ     [NF];
   cnt_t              free_ff     [NF];
   cnt_t              nxt_free    [NF];
   logic [NF-1:0]     on_ff,      nxt_on;
   logic [NF-1:0]     ps_ff,      nxt_ps;
   logic [NF-1:0]     long_ff,    nxt_long;
   res_e [NF-1:0]     res_ff,     nxt_res;
   cnt_t              n_w         [NF];
   cnt_t              ncs_w       [NF];
   cnt_t              clr_w       [NF];

   function automatic cnt_t clamp_n(input cnt_t v);
      if (v < `SD_N_MIN) begin
         return `SD_N_MIN;
      end
      if (v > `SD_N_MAX) begin
         return `SD_N_MAX;
      end
      return v;
   endfunction

   function automatic cnt_t clamp_1(input cnt_t v, input cnt_t hi);
      if (v > hi) begin
         return hi;
      end
      if (v == 5'h00) begin
         return 5'h01;
      end
      return v;
   endfunction

   function automatic logic res_ok(input logic [2:0] c);
      return (c <= `SD_RES_MAX) && ((c != 3'(RES_60)) || HAS_60MM);
   endfunction

   function automatic logic [7:0] cyc_ms(input logic fast);
      if (LONG_RANGE) begin
         return fast ? `SD_CYC_LONG_FAST_MS : `SD_CYC_LONG_FULL_MS;
      end
      return fast ? `SD_CYC_SHORT_FAST_MS : `SD_CYC_SHORT_FULL_MS;
   endfunction

   // Register file; illegal codes are dropped so no unsafe setting can be stored
   always_comb begin
      logic [31:0] fw;
      fw        = '0;
      nxt_pcfg  = pcfg_ff;
      nxt_fcfg  = fcfg_ff;
      nxt_rdata = '0;
      if (wr_i && (addr_i == `SD_ADDR_CTRL)) begin
         nxt_pcfg.samples  = clamp_n(wdata_i[`SD_C_N +: 5]);
         nxt_pcfg.ncs_user = wdata_i[`SD_C_NCS +: 5];
         nxt_pcfg.clr_en   = wdata_i[`SD_C_CLREN];
         nxt_pcfg.clr_cnt  = clamp_1(wdata_i[`SD_C_CLR +: 5], `SD_N_MAX);
         nxt_pcfg.fast_cyc = wdata_i[`SD_C_FAST];
         nxt_pcfg.intf     = wdata_i[`SD_C_INTF +: 2];
         if (wdata_i[`SD_C_PS +: 2] != 2'h3) begin
            nxt_pcfg.ps_mode = ps_mode_e'(wdata_i[`SD_C_PS +: 2]);
         end
         if (res_ok(wdata_i[`SD_C_RES +: 3])) begin
            nxt_pcfg.res = res_e'(wdata_i[`SD_C_RES +: 3]);
         end
      end
      for (int i = 0; i < NF; i++) begin
         if (wr_i && (addr_i == `SD_ADDR_FLD + 8'(`SD_FLD_STRIDE * i))) begin
            nxt_fcfg[i].ovr     = wdata_i[`SD_F_OVR];
            nxt_fcfg[i].samples = clamp_n(wdata_i[`SD_F_N +: 5]);
            nxt_fcfg[i].clr_cnt = clamp_1(wdata_i[`SD_F_CLR +: 5], `SD_N_MAX);
            if (res_ok(wdata_i[`SD_F_RES +: 3])) begin
               nxt_fcfg[i].res = res_e'(wdata_i[`SD_F_RES +: 3]);
            end
         end
         if (rd_i && (addr_i == `SD_ADDR_FLD + 8'(`SD_FLD_STRIDE * i))) begin
            fw[`SD_F_OVR]      = fcfg_ff[i].ovr;
            fw[`SD_F_N +: 5]   = fcfg_ff[i].samples;
            fw[`SD_F_RES +: 3] = fcfg_ff[i].res;
            fw[`SD_F_CLR +: 5] = fcfg_ff[i].clr_cnt;
            nxt_rdata          = fw;
         end
      end
      if (rd_i && (addr_i == `SD_ADDR_CTRL)) begin
         nxt_rdata[`SD_C_N +: 5]   = pcfg_ff.samples;
         nxt_rdata[`SD_C_PS +: 2]  = pcfg_ff.ps_mode;
         nxt_rdata[`SD_C_NCS +: 5] = pcfg_ff.ncs_user;
         nxt_rdata[`SD_C_CLREN]    = pcfg_ff.clr_en;
         nxt_rdata[`SD_C_CLR +: 5] = pcfg_ff.clr_cnt;
         nxt_rdata[`SD_C_FAST]     = pcfg_ff.fast_cyc;
         nxt_rdata[`SD_C_INTF +: 2] = pcfg_ff.intf;
         nxt_rdata[`SD_C_RES +: 3] = pcfg_ff.res;
      end
      if (rd_i && (addr_i == `SD_ADDR_STAT)) begin
         nxt_rdata[`SD_S_ON +: NF]  = on_ff;
         nxt_rdata[`SD_S_PS +: NF]  = ps_ff;
         nxt_rdata[`SD_S_PER +: 8]  = period_w;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pcfg_ff <= '{samples: `SD_RST_N, ps_mode: PS_FAST, ncs_user: `SD_RST_NCS, clr_en: 1'b0,
                      clr_cnt: `SD_RST_CLR, fast_cyc: 1'b0, intf: 2'h0, res: res_e'(`SD_RST_RES)};
         for (int i = 0; i < NF; i++) begin
            fcfg_ff[i] <= '{ovr: 1'b0, samples: `SD_RST_N, res: res_e'(`SD_RST_RES), clr_cnt: `SD_RST_CLR};
         end
         rdata_ff <= '0;
      end else begin
         pcfg_ff  <= nxt_pcfg;
         fcfg_ff  <= nxt_fcfg;
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata_o = rdata_ff;

   // Scan time base: cycle time plus interference supplement
   assign period_w = cyc_ms(pcfg_ff.fast_cyc) + 8'(`SD_INTF_STEP_MS * pcfg_ff.intf);

   always_comb begin
      nxt_ms_cnt  = ms_cnt_ff + MSW'(1);
      nxt_per_cnt = per_cnt_ff;
      nxt_tick    = 1'b0;
      if (ms_cnt_ff >= MSW'(CYC_PER_MS - 1)) begin
         nxt_ms_cnt = '0;
         // Compare with >= so a shorter period written mid-scan cannot overrun
         if (per_cnt_ff >= period_w - 8'h01) begin
            nxt_per_cnt = '0;
            nxt_tick    = 1'b1;
         end else begin
            nxt_per_cnt = per_cnt_ff + 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ms_cnt_ff  <= '0;
         per_cnt_ff <= '0;
         tick_ff    <= 1'b0;
      end else begin
         ms_cnt_ff  <= nxt_ms_cnt;
         per_cnt_ff <= nxt_per_cnt;
         tick_ff    <= nxt_tick;
      end
   end

   assign scan_tick_o = tick_ff;

   // Effective per-field thresholds
   always_comb begin
      cnt_t clr_base;
      clr_base = '0;
      for (int i = 0; i < NF; i++) begin
         n_w[i]     = fcfg_ff[i].ovr ? fcfg_ff[i].samples : pcfg_ff.samples;
         nxt_res[i] = fcfg_ff[i].ovr ? fcfg_ff[i].res : pcfg_ff.res;
         case (pcfg_ff.ps_mode)
            PS_FAST:   ncs_w[i] = `SD_NCS_FAST;
            PS_ROBUST: ncs_w[i] = n_w[i] - 5'h01;
            PS_USER:   ncs_w[i] = clamp_1(pcfg_ff.ncs_user, n_w[i] - 5'h01);
            default:   ncs_w[i] = `SD_NCS_FAST;
         endcase
         if (pcfg_ff.clr_en) begin
            clr_base = fcfg_ff[i].ovr ? fcfg_ff[i].clr_cnt : pcfg_ff.clr_cnt;
         end else begin
            clr_base = n_w[i];
         end
         clr_w[i] = (long_ff[i] && (clr_base < `SD_CLR_LONG)) ? `SD_CLR_LONG : clr_base;
      end
   end

   // Per-field debounce; safety outputs start OFF until the field is proven free
   always_comb begin
      cnt_t occ_inc;
      occ_inc  = '0;
      nxt_occ  = occ_ff;
      nxt_free = free_ff;
      nxt_on   = on_ff;
      nxt_ps   = ps_ff;
      nxt_long = long_ff;
      for (int i = 0; i < NF; i++) begin
         occ_inc = (occ_ff[i] == `SD_CNT_SAT) ? `SD_CNT_SAT : occ_ff[i] + 5'h01;
         if (tick_ff && field_occ_i[i]) begin
            nxt_occ[i]  = occ_inc;
            nxt_free[i] = '0;
            if (on_ff[i] && (occ_inc >= (ps_ff[i] ? ncs_w[i] : n_w[i]))) begin
               nxt_on[i] = 1'b0;
               nxt_ps[i] = 1'b0;
            end
            if (!on_ff[i] && (occ_inc >= LONG_SCANS)) begin
               nxt_long[i] = 1'b1;
            end
         end else if (tick_ff) begin
            nxt_occ[i] = '0;
            nxt_ps[i]  = 1'b0;
            if (!on_ff[i]) begin
               if (free_ff[i] + 5'h01 >= clr_w[i]) begin
                  nxt_on[i]   = 1'b1;
                  nxt_free[i] = '0;
                  nxt_long[i] = 1'b0;
               end else begin
                  nxt_free[i] = free_ff[i] + 5'h01;
               end
            end
         end
         // A switch arriving with a tick wins: the new case starts counting afresh
         if (case_switch_i) begin
            nxt_ps[i]  = 1'b1;
            nxt_occ[i] = '0;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < NF; i++) begin
            occ_ff[i]  <= '0;
            free_ff[i] <= '0;
            res_ff[i]  <= res_e'(`SD_RST_RES);
         end
         on_ff   <= '0;
         ps_ff   <= '0;
         long_ff <= '0;
      end else begin
         occ_ff  <= nxt_occ;
         free_ff <= nxt_free;
         on_ff   <= nxt_on;
         ps_ff   <= nxt_ps;
         long_ff <= nxt_long;
         res_ff  <= nxt_res;
      end
   end

   assign safe_on_o   = on_ff;
   assign field_res_o = res_ff;

   // Checks on field 0 stand for all fields
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   a_n_range: assert property (n_w[0] >= 5'h02 && n_w[0] <= 5'h10)
      else $error("Sample count out of range");
   a_fast_trip: assert property (tick_ff && field_occ_i[0] && on_ff[0] && ps_ff[0] && !case_switch_i
      && pcfg_ff.ps_mode == PS_FAST |=> !on_ff[0])
      else $error("Fast post-switch trip missed");
   a_robust_trip: assert property (tick_ff && field_occ_i[0] && on_ff[0] && ps_ff[0] && !case_switch_i
      && pcfg_ff.ps_mode == PS_ROBUST && occ_ff[0] + 5'h01 == n_w[0] - 5'h01 |=> !on_ff[0])
      else $error("Robust post-switch trip missed");
   a_ncs_bound: assert property (ncs_w[0] <= n_w[0] - 5'h01 && ncs_w[0] >= 5'h01)
      else $error("Post-switch count above limit");
   a_restore_cnt: assert property (!on_ff[0] ##1 on_ff[0] |-> $past(free_ff[0]) + 5'h01 >= $past(clr_w[0])
      && $past(tick_ff) && !$past(field_occ_i[0]))
      else $error("Restored before enough free scans");
   a_clr_default: assert property (!pcfg_ff.clr_en && !long_ff[0] |-> clr_w[0] == n_w[0])
      else $error("Default free count differs from detection count");
   a_clr_plane: assert property (pcfg_ff.clr_en && !fcfg_ff[0].ovr && !long_ff[0]
      |-> clr_w[0] == pcfg_ff.clr_cnt)
      else $error("Plane free count not applied");
   a_long_floor: assert property (long_ff[0] |-> clr_w[0] >= 5'h06)
      else $error("Long occupancy free count below six");
   a_period_set: assert property (LONG_RANGE ? (period_w - 8'(pcfg_ff.intf) == (pcfg_ff.fast_cyc ? 8'h28 : 8'h32))
      : (period_w - 8'(pcfg_ff.intf) == (pcfg_ff.fast_cyc ? 8'h1E : 8'h28)))
      else $error("Scan period wrong");
   a_field_inherit: assert property (!fcfg_ff[0].ovr |=> res_ff[0] == $past(pcfg_ff.res))
      else $error("Field does not inherit plane size");
   a_res_legal: assert property (HAS_60MM || pcfg_ff.res != RES_60)
      else $error("Unavailable object size stored");
   a_occ_restart: assert property (tick_ff && !field_occ_i[0] |=> occ_ff[0] == 5'h00)
      else $error("Occupied count not restarted");
   a_free_restart: assert property (tick_ff && field_occ_i[0] |=> free_ff[0] == 5'h00)
      else $error("Free count not restarted");

   c_trip: cover property (on_ff[0] ##1 !on_ff[0]);
   c_restore: cover property (!on_ff[0] ##1 on_ff[0]);
   c_post_switch_trip: cover property (ps_ff[0] && on_ff[0] ##1 !on_ff[0]);
   c_long_hold: cover property (long_ff[0] ##1 on_ff[0]);

endmodule

// ---- verif/machine_ctrl_model.sv ----
`timescale 1ns/100ps

module machine_ctrl_model #(
   parameter int NF = 4
) (
   // Clock and reset
   input  wire logic          sys_clk_i,
   input  wire logic          rst_i,
   // Scanner side
   input  wire logic [NF-1:0] safe_on_i,
   input  wire logic          scan_tick_i,
   // Bench side
   input  wire logic          sw_req_i,
   input  wire logic [4:0]    hold_scans_i,
   output logic               case_switch_o,
   output logic [7:0]         stop_cnt_o
);
   logic          pend_ff;
   logic [4:0]    age_ff;
   logic [NF-1:0] last_on_ff;

   // Behavioural, so one process holds state and outputs alike
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_ff       <= 1'b0;
         age_ff        <= 5'h1F;
         last_on_ff    <= '0;
         case_switch_o <= 1'b0;
         stop_cnt_o    <= 8'h00;
      end else begin
         case_switch_o <= 1'b0;
         last_on_ff    <= safe_on_i;
         if (sw_req_i) begin
            pend_ff <= 1'b1;
         end
         if (scan_tick_i && age_ff != 5'h1F) begin
            age_ff <= age_ff + 5'h01;
         end
         // Decided only while scan_tick_i is low; the registered switch rises a clock later and can still coincide with a tick
         if (pend_ff && !scan_tick_i && age_ff >= hold_scans_i) begin
            case_switch_o <= 1'b1;
            pend_ff       <= 1'b0;
            age_ff        <= 5'h00;
         end
         if ((last_on_ff & ~safe_on_i) != '0) begin
            stop_cnt_o <= stop_cnt_o + 8'h01;
         end
      end
   end
endmodule

// ---- verif/tb_scan_detection_debounce.sv ----
`timescale 1ns/100ps
`include "scan_debounce_defs.svh"

module tb_scan_detection_debounce;
   import scan_debounce_pkg::*;
   localparam int NF  = 4;
   localparam int CPM = 4;
   logic          sys_clk_i   = 1'b0;
   logic          rst_i       = 1'b1;
   logic [7:0]    addr_i      = 8'h00;
   logic [31:0]   wdata_i     = 32'h0;
   logic          wr_i        = 1'b0;
   logic          rd_i        = 1'b0;
   logic [NF-1:0] field_occ_i = '0;
   logic          sw_req      = 1'b0;
   logic [4:0]    hold_scans  = 5'h01;
   logic [31:0]   rdata_o;
   logic          case_switch_i;
   logic          scan_tick_o;
   res_e [NF-1:0] field_res_o;
   logic [NF-1:0] safe_on_o;
   logic [7:0]    stop_cnt;
   logic [31:0]   rd_val;
   int            err_total   = 0;
   int            check_count = 0;

   always #5 sys_clk_i = ~sys_clk_i;

   scan_detection_debounce #(.NF(NF), .CYC_PER_MS(CPM), .LONG_RANGE(1'b0), .HAS_60MM(1'b1),
                             .LONG_SCANS(5'h04)) i_dut (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .field_occ_i(field_occ_i), .case_switch_i(case_switch_i),
      .scan_tick_o(scan_tick_o), .field_res_o(field_res_o), .safe_on_o(safe_on_o));

   machine_ctrl_model #(.NF(NF)) i_ctrl (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .safe_on_i(safe_on_o), .scan_tick_i(scan_tick_o),
      .sw_req_i(sw_req), .hold_scans_i(hold_scans), .case_switch_o(case_switch_i), .stop_cnt_o(stop_cnt));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge sys_clk_i);
      wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge sys_clk_i);
      rd_i   <= 1'b0;
      #1 rd_val = rdata_o;
   endtask

   // Returns just after the edge that evaluates the scan
   task automatic tick();
      int i;
      for (i = 0; i < 400; i++) begin
         @(negedge sys_clk_i);
         if (scan_tick_o === 1'b1) break;
      end
      if (i == 400) begin
         err_total++;
         finish_test();
      end
      @(negedge sys_clk_i);
   endtask

   task automatic scans(input logic [NF-1:0] occ, input int k);
      @(posedge sys_clk_i);
      field_occ_i <= occ;
      repeat (k) tick();
      // Keep later compares off the launching edge
      if (k == 0) @(negedge sys_clk_i);
   endtask

   task automatic cfg(input logic [31:0] w);
      wr(`SD_ADDR_CTRL, w);
      scans(4'h0, 2);
   endtask

   task automatic do_switch(input logic [4:0] hs);
      int i;
      @(posedge sys_clk_i);
      hold_scans <= hs;
      sw_req     <= 1'b1;
      @(posedge sys_clk_i);
      sw_req     <= 1'b0;
      for (i = 0; i < 400 && case_switch_i !== 1'b1; i++) @(negedge sys_clk_i);
      if (i == 400) begin
         err_total++;
         finish_test();
      end
   endtask

   task automatic t_reset();
      cmp(32'(safe_on_o), 32'h0);
      cmp(32'(field_res_o[2]), 32'(RES_40));
      rd(`SD_ADDR_CTRL);
      cmp(rd_val, 32'h0020_4082);
      scans(4'h0, 1);
      cmp(32'(safe_on_o), 32'h0);
      scans(4'h0, 1);
      cmp(32'(safe_on_o), 32'hF);
   endtask

   // Written counts 1 and 17 fall outside the legal range
   task automatic t_count();
      int         nw[4] = '{1, 8, 16, 17};
      int         ne[4] = '{2, 8, 16, 16};
      logic [7:0] s;
      for (int k = 0; k < 4; k++) begin
         cfg({8'h00, 3'h1, 2'h0, 1'b0, 5'h02, 1'b0, 5'h01, 2'h0, 5'(nw[k])});
         scans(4'h1, ne[k] - 1);
         scans(4'h0, 1);
         scans(4'h1, ne[k] - 1);
         cmp(32'(safe_on_o), 32'hF);
         s = stop_cnt;
         scans(4'h1, 1);
         cmp(32'(safe_on_o), 32'hE);
         // Controller registers the falling output one clock later
         @(negedge sys_clk_i);
         cmp(32'(stop_cnt), 32'(s + 8'h01));
         scans(4'h0, ne[k] - 1);
         scans(4'h1, 1);
         scans(4'h0, ne[k] - 1);
         cmp(32'(safe_on_o), 32'hE);
         scans(4'h0, 1);
         cmp(32'(safe_on_o), 32'hF);
      end
   endtask

   task automatic t_ps();
      int ps[4] = '{0, 1, 2, 2};
      int nc[4] = '{1, 1, 9, 2};
      int ex[4] = '{1, 3, 3, 2};
      for (int k = 0; k < 4; k++) begin
         cfg({8'h00, 3'h1, 2'h0, 1'b0, 5'h02, 1'b0, 5'(nc[k]), 2'(ps[k]), 5'h04});
         do_switch(5'(ex[k]));
         scans(4'h1, ex[k] - 1);
         cmp(32'(safe_on_o), 32'hF);
         scans(4'h1, 1);
         cmp(32'(safe_on_o), 32'hE);
         scans(4'h0, 4);
         cmp(32'(safe_on_o), 32'hF);
      end
   endtask

   task automatic t_clear();
      cfg({8'h00, 3'h1, 2'h0, 1'b0, 5'h03, 1'b1, 5'h01, 2'h0, 5'h02});
      wr(`SD_ADDR_FLD + `SD_FLD_STRIDE, 32'h0000_0B85);
      repeat (2) @(negedge sys_clk_i);
      cmp(32'(field_res_o[1]), 32'(RES_200));
      cmp(32'(field_res_o[0]), 32'(RES_40));
      scans(4'h3, 2);
      cmp(32'(safe_on_o), 32'hC);
      scans(4'h0, 2);
      cmp(32'(safe_on_o), 32'hC);
      scans(4'h0, 1);
      cmp(32'(safe_on_o), 32'hD);
      scans(4'h0, 1);
      cmp(32'(safe_on_o), 32'hD);
      scans(4'h0, 1);
      cmp(32'(safe_on_o), 32'hF);
      wr(`SD_ADDR_FLD + `SD_FLD_STRIDE, 32'h0);
   endtask

   task automatic t_long();
      cfg({8'h00, 3'h1, 2'h0, 1'b0, 5'h02, 1'b0, 5'h01, 2'h0, 5'h02});
      scans(4'h1, 6);
      scans(4'h0, 5);
      cmp(32'(safe_on_o), 32'hE);
      scans(4'h0, 1);
      cmp(32'(safe_on_o), 32'hF);
   endtask

   task automatic t_period();
      int c;
      int ms;
      for (int f = 0; f < 2; f++) begin
         for (int m = 0; m < 4; m++) begin
            cfg({8'h00, 3'h1, 2'(m), 1'(f), 5'h02, 1'b0, 5'h01, 2'h0, 5'h02});
            ms = (f == 1 ? 30 : 40) + m;
            c = 0;
            do begin
               @(negedge sys_clk_i);
               c++;
            end while (scan_tick_o !== 1'b1 && c < 400);
            cmp(32'(c), 32'(ms * CPM - 1));
            if (c >= 400) begin
               finish_test();
            end
            rd(`SD_ADDR_STAT);
            cmp(32'(rd_val[23:16]), 32'(ms));
         end
      end
   endtask

   // Code 7 is no size at all and must leave the last one in force
   task automatic t_res();
      logic [2:0] e;
      for (int r = 0; r < 8; r++) begin
         e = (r == 7) ? 3'h6 : 3'(r);
         wr(`SD_ADDR_CTRL, {8'h00, 3'(r), 2'h0, 1'b0, 5'h02, 1'b0, 5'h01, 2'h0, 5'h02});
         repeat (2) @(negedge sys_clk_i);
         cmp(32'(field_res_o[0]), 32'(e));
         cmp(32'(field_res_o[3]), 32'(e));
      end
      rd(8'h40);
      cmp(rd_val, 32'h0);
   endtask

   initial begin
      repeat (6) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(negedge sys_clk_i);
      t_reset();
      t_count();
      t_ps();
      t_clear();
      t_long();
      t_period();
      t_res();
      finish_test();
   end
endmodule
